//--- verilog/mifc_top.sv
// interrupt request flags, enables, priority vectoring and wake for a small mcu
// assumes same-clock peripheral event pulses and a core that pushes/pops on strobes
//
// Behaviour
// - comparator p flag at bit 7, enable at bit 3 of second register, reset 0.
// - tick 1 flag at bit 6 of second register, 1 means pending.
// - tick 0 flag at bit 5 of second register, 1 means pending.
// - nvm write flag at bit 4, enable at bit 0 of second register.
// - tick 1 enable at bit 2 of second register.
// - tick 0 enable at bit 1 of second register.
// - comparator a flag at bit 4 of third register, reset 0.
// - comparator a enable at bit 0 of third register.
// - third register bits 7..5 and 3..1 read zero.
// - source event sets its flag whatever the enable.
// - flag vectors only when its own enable is set.
// - global enable low blocks every vector jump.
// - on entry push next pc and load the source vector.
// - every source has a distinct vector address.
// - return from interrupt pops the saved pc.
// - entry clears global enable; later requests still latch flags.
// - full stack blocks every acknowledge until it drains.
// - any set flag wakes the device from sleep or idle.
// - global enable at bit 0 of first register, reset 0.
// - servicing clears the source flag together with global enable.
module mifc_top
  import mifc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire mifc_apb_req_type apb_req,
  output mifc_apb_rsp_type apb_rsp,
  input wire logic [NUM_SRC-1:0] src_event,
  input wire logic stack_full,
  input wire logic [PC_W-1:0] next_pc,
  input wire logic return_from_irq,
  output mifc_core_type core,
  output logic wake
);

  // ==========================================================
  // state
  mifc_state_type s;
  mifc_state_type next_s;
  logic acc;
  logic done;
  logic [NUM_SRC-1:0] pend;
  logic [2:0] idx;

  assign apb_rsp = s.apb;
  assign core = s.core;
  assign wake = s.wake;

  // ==========================================================
  // next state
  always_comb begin
    next_s = s;
    next_s.apb.pready = 1'b0;
    next_s.apb.pslverr = 1'b0;
    next_s.core.push = 1'b0;
    next_s.core.pop = return_from_irq;
    acc = apb_req.psel & apb_req.penable;
    done = acc & s.apb.pready;
    pend = s.flag & s.en;
    idx = mifc_pick(pend);
    // one wait state keeps prdata straight from a flop
    if (acc && !s.apb.pready) begin
      next_s.apb.pready = 1'b1;
      next_s.apb.prdata = 32'h0000_0000;
      case (apb_req.paddr)
        ADDR_FIRST: next_s.apb.prdata[BIT_GLOBAL_EN] = s.global_en;
        ADDR_SECOND: begin
          next_s.apb.prdata[BIT_CMP_P_FLAG] = s.flag[SRC_CMP_P];
          next_s.apb.prdata[BIT_TICK1_FLAG] = s.flag[SRC_TICK1];
          next_s.apb.prdata[BIT_TICK0_FLAG] = s.flag[SRC_TICK0];
          next_s.apb.prdata[BIT_NVM_FLAG] = s.flag[SRC_NVM];
          next_s.apb.prdata[BIT_CMP_P_EN] = s.en[SRC_CMP_P];
          next_s.apb.prdata[BIT_TICK1_EN] = s.en[SRC_TICK1];
          next_s.apb.prdata[BIT_TICK0_EN] = s.en[SRC_TICK0];
          next_s.apb.prdata[BIT_NVM_EN] = s.en[SRC_NVM];
        end
        ADDR_THIRD: begin
          next_s.apb.prdata[BIT_CMP_A_FLAG] = s.flag[SRC_CMP_A];
          next_s.apb.prdata[BIT_CMP_A_EN] = s.en[SRC_CMP_A];
        end
        ADDR_STATUS: next_s.apb.prdata[7:0] = {s.wake, s.last_src, 3'h0, s.global_en};
        default: next_s.apb.pslverr = 1'b1;
      endcase
    end
    // writes land at the completing edge only
    if (done && apb_req.pwrite) begin
      case (apb_req.paddr)
        ADDR_FIRST: next_s.global_en = apb_req.pwdata[BIT_GLOBAL_EN];
        ADDR_SECOND: begin
          next_s.flag[SRC_CMP_P] = apb_req.pwdata[BIT_CMP_P_FLAG];
          next_s.flag[SRC_TICK1] = apb_req.pwdata[BIT_TICK1_FLAG];
          next_s.flag[SRC_TICK0] = apb_req.pwdata[BIT_TICK0_FLAG];
          next_s.flag[SRC_NVM] = apb_req.pwdata[BIT_NVM_FLAG];
          next_s.en[SRC_CMP_P] = apb_req.pwdata[BIT_CMP_P_EN];
          next_s.en[SRC_TICK1] = apb_req.pwdata[BIT_TICK1_EN];
          next_s.en[SRC_TICK0] = apb_req.pwdata[BIT_TICK0_EN];
          next_s.en[SRC_NVM] = apb_req.pwdata[BIT_NVM_EN];
        end
        ADDR_THIRD: begin
          next_s.flag[SRC_CMP_A] = apb_req.pwdata[BIT_CMP_A_FLAG];
          next_s.en[SRC_CMP_A] = apb_req.pwdata[BIT_CMP_A_EN];
        end
        default: next_s.global_en = next_s.global_en;
      endcase
    end
    // service entry beats a same-cycle software write of global enable
    if (s.global_en && (pend != '0) && !stack_full) begin
      next_s.core.push = 1'b1;
      next_s.core.push_addr = next_pc;
      next_s.core.vector = mifc_vec(idx);
      next_s.flag[idx] = 1'b0;
      next_s.global_en = 1'b0;
      next_s.last_src = idx;
    end
    // events win over any clear in the same cycle
    next_s.flag = next_s.flag | src_event;
    next_s.wake = |next_s.flag;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence seq_rd_third;
    apb_req.psel && apb_req.penable && !apb_req.pwrite && !s.apb.pready
      && apb_req.paddr == ADDR_THIRD;
  endsequence

  sequence seq_wr_second;
    apb_req.psel && apb_req.penable && apb_req.pwrite && s.apb.pready
      && apb_req.paddr == ADDR_SECOND && src_event == '0 && !s.global_en;
  endsequence

  property p_bits_second;
    seq_wr_second |=> s.en[SRC_CMP_P] == $past(apb_req.pwdata[BIT_CMP_P_EN])
      && s.flag[SRC_CMP_P] == $past(apb_req.pwdata[BIT_CMP_P_FLAG]);
  endproperty
  a_bits_second: assert property (p_bits_second) else $error("second register map wrong");

  property p_third_zero;
    seq_rd_third |=> s.apb.pready && s.apb.prdata[7:5] == 3'h0 && s.apb.prdata[3:1] == 3'h0;
  endproperty
  a_third_zero: assert property (p_third_zero) else $error("third register reserved bits set");

  property p_event_sets;
    (src_event != '0) |=> ((s.flag & $past(src_event)) == $past(src_event));
  endproperty
  a_event_sets: assert property (p_event_sets) else $error("event lost its flag");

  property p_needs_enable;
    s.core.push |-> (($past(s.en) & (5'h01 << s.last_src)) != 5'h00);
  endproperty
  a_needs_enable: assert property (p_needs_enable) else $error("vector without enable");

  property p_needs_global;
    s.core.push |-> $past(s.global_en);
  endproperty
  a_needs_global: assert property (p_needs_global) else $error("vector with global off");

  property p_push_addr;
    s.core.push |-> s.core.push_addr == $past(next_pc) && s.core.vector == mifc_vec(s.last_src);
  endproperty
  a_push_addr: assert property (p_push_addr) else $error("push address or vector wrong");

  property p_pop;
    return_from_irq |=> s.core.pop;
  endproperty
  a_pop: assert property (p_pop) else $error("return did not pop");

  property p_entry_clears;
    s.core.push |-> !s.global_en ##1 !s.core.push;
  endproperty
  a_entry_clears: assert property (p_entry_clears) else $error("global enable not cleared");

  property p_stack_full;
    stack_full |=> !s.core.push;
  endproperty
  a_stack_full: assert property (p_stack_full) else $error("acknowledge with stack full");

  property p_wake;
    (s.flag != 5'h00) |-> s.wake;
  endproperty
  a_wake: assert property (p_wake) else $error("flag set without wake");

  property p_priority;
    s.core.push |-> (($past(s.flag & s.en) & ((5'h01 << s.last_src) - 5'h01)) == 5'h00);
  endproperty
  a_priority: assert property (p_priority) else $error("lower priority served first");

  // ==========================================================
  // register map and service sequences
  // writes checked only when no event or entry can disturb the same edge
  sequence seq_wr_third;
    apb_req.psel && apb_req.penable && apb_req.pwrite && s.apb.pready
      && apb_req.paddr == ADDR_THIRD && src_event == '0 && !s.global_en;
  endsequence

  sequence seq_rd_second;
    apb_req.psel && apb_req.penable && !apb_req.pwrite && !s.apb.pready
      && apb_req.paddr == ADDR_SECOND;
  endsequence

  sequence seq_rd_first;
    apb_req.psel && apb_req.penable && !apb_req.pwrite && !s.apb.pready
      && apb_req.paddr == ADDR_FIRST;
  endsequence

  sequence seq_entry;
    s.global_en && ((s.flag & s.en) != 5'h00) && !stack_full;
  endsequence

  sequence seq_wr_first;
    apb_req.psel && apb_req.penable && apb_req.pwrite && s.apb.pready
      && apb_req.paddr == ADDR_FIRST
      && !(s.global_en && ((s.flag & s.en) != 5'h00) && !stack_full);
  endsequence

  property p_tick1_flag;
    seq_wr_second |=> s.flag[SRC_TICK1] == $past(apb_req.pwdata[BIT_TICK1_FLAG]);
  endproperty
  a_tick1_flag: assert property (p_tick1_flag) else $error("tick 1 flag misplaced");

  property p_tick0_flag;
    seq_wr_second |=> s.flag[SRC_TICK0] == $past(apb_req.pwdata[BIT_TICK0_FLAG]);
  endproperty
  a_tick0_flag: assert property (p_tick0_flag) else $error("tick 0 flag misplaced");

  property p_nvm_bits;
    seq_wr_second |=> s.flag[SRC_NVM] == $past(apb_req.pwdata[BIT_NVM_FLAG])
      && s.en[SRC_NVM] == $past(apb_req.pwdata[BIT_NVM_EN]);
  endproperty
  a_nvm_bits: assert property (p_nvm_bits) else $error("nvm write bits misplaced");

  property p_tick1_en;
    seq_wr_second |=> s.en[SRC_TICK1] == $past(apb_req.pwdata[BIT_TICK1_EN]);
  endproperty
  a_tick1_en: assert property (p_tick1_en) else $error("tick 1 enable misplaced");

  property p_tick0_en;
    seq_wr_second |=> s.en[SRC_TICK0] == $past(apb_req.pwdata[BIT_TICK0_EN]);
  endproperty
  a_tick0_en: assert property (p_tick0_en) else $error("tick 0 enable misplaced");

  property p_cmp_a_flag;
    seq_wr_third |=> s.flag[SRC_CMP_A] == $past(apb_req.pwdata[BIT_CMP_A_FLAG]);
  endproperty
  a_cmp_a_flag: assert property (p_cmp_a_flag) else $error("comparator a flag misplaced");

  property p_cmp_a_en;
    seq_wr_third |=> s.en[SRC_CMP_A] == $past(apb_req.pwdata[BIT_CMP_A_EN]);
  endproperty
  a_cmp_a_en: assert property (p_cmp_a_en) else $error("comparator a enable misplaced");

  property p_rd_second;
    seq_rd_second |=> s.apb.prdata[BIT_CMP_P_FLAG] == $past(s.flag[SRC_CMP_P])
      && s.apb.prdata[BIT_CMP_P_EN] == $past(s.en[SRC_CMP_P]);
  endproperty
  a_rd_second: assert property (p_rd_second) else $error("second register read wrong");

  property p_rd_first;
    seq_rd_first |=> s.apb.prdata[BIT_GLOBAL_EN] == $past(s.global_en)
      && s.apb.prdata[31:1] == 31'h0000_0000;
  endproperty
  a_rd_first: assert property (p_rd_first) else $error("first register read wrong");

  property p_wr_first;
    seq_wr_first |=> s.global_en == $past(apb_req.pwdata[BIT_GLOBAL_EN]);
  endproperty
  a_wr_first: assert property (p_wr_first) else $error("global enable write lost");

  property p_entry_taken;
    seq_entry |=> s.core.push;
  endproperty
  a_entry_taken: assert property (p_entry_taken) else $error("pending request not taken");

  property p_disabled_idle;
    (s.global_en && ((s.flag & s.en) == 5'h00)) |=> !s.core.push;
  endproperty
  a_disabled_idle: assert property (p_disabled_idle) else $error("push with no enabled flag");

  property p_global_off;
    !s.global_en |=> !s.core.push;
  endproperty
  a_global_off: assert property (p_global_off) else $error("push while globally off");

  property p_flag_cleared;
    s.core.push |-> !s.flag[s.last_src] || $past(src_event[s.last_src]);
  endproperty
  a_flag_cleared: assert property (p_flag_cleared) else $error("serviced flag left set");

  property p_wake_low;
    (s.flag == 5'h00) |-> !s.wake;
  endproperty
  a_wake_low: assert property (p_wake_low) else $error("wake with no flag");

endmodule

//--- verilog/mifc_pkg.sv
// constants, field positions and carrier types for the interrupt flag control block
// assumes an apb master with 8-bit byte addresses and a core that owns pc and stack
package mifc_pkg;

  // ==========================================================
  // register byte addresses
  localparam logic [7:0] ADDR_FIRST = 8'h00;
  localparam logic [7:0] ADDR_SECOND = 8'h04;
  localparam logic [7:0] ADDR_THIRD = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;

  // ==========================================================
  // field positions
  localparam int BIT_GLOBAL_EN = 0;
  localparam int BIT_CMP_P_FLAG = 7;
  localparam int BIT_TICK1_FLAG = 6;
  localparam int BIT_TICK0_FLAG = 5;
  localparam int BIT_NVM_FLAG = 4;
  localparam int BIT_CMP_P_EN = 3;
  localparam int BIT_TICK1_EN = 2;
  localparam int BIT_TICK0_EN = 1;
  localparam int BIT_NVM_EN = 0;
  localparam int BIT_CMP_A_FLAG = 4;
  localparam int BIT_CMP_A_EN = 0;

  // ==========================================================
  // sources, index order is priority order (lowest index wins)
  localparam int NUM_SRC = 5;
  localparam int SRC_CMP_P = 0;
  localparam int SRC_CMP_A = 1;
  localparam int SRC_NVM = 2;
  localparam int SRC_TICK0 = 3;
  localparam int SRC_TICK1 = 4;

  localparam int PC_W = 12;
  localparam logic [PC_W-1:0] VEC_CMP_P = 12'h010;
  localparam logic [PC_W-1:0] VEC_CMP_A = 12'h014;
  localparam logic [PC_W-1:0] VEC_NVM = 12'h018;
  localparam logic [PC_W-1:0] VEC_TICK0 = 12'h01C;
  localparam logic [PC_W-1:0] VEC_TICK1 = 12'h020;

  localparam logic [7:0] REG_RESET = 8'h00;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } mifc_apb_req_type;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } mifc_apb_rsp_type;

  typedef struct packed {
    logic push;
    logic pop;
    logic [PC_W-1:0] push_addr;
    logic [PC_W-1:0] vector;
  } mifc_core_type;

  typedef struct packed {
    mifc_apb_rsp_type apb;
    mifc_core_type core;
    logic [NUM_SRC-1:0] flag;
    logic [NUM_SRC-1:0] en;
    logic global_en;
    logic [2:0] last_src;
    logic wake;
  } mifc_state_type;

  function automatic logic [2:0] mifc_pick(input logic [NUM_SRC-1:0] p);
    logic [2:0] r;
    r = 3'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (p[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [PC_W-1:0] mifc_vec(input logic [2:0] idx);
    case (idx)
      3'(SRC_CMP_P): return VEC_CMP_P;
      3'(SRC_CMP_A): return VEC_CMP_A;
      3'(SRC_NVM): return VEC_NVM;
      3'(SRC_TICK0): return VEC_TICK0;
      default: return VEC_TICK1;
    endcase
  endfunction

endpackage

//--- verification/mifc_core_model.sv
// behavioural core stack facing the interrupt block
// assumes push and pop strobes on the shared clock, one per cycle
module mifc_core_model
  import mifc_pkg::*;
#(
  parameter int DEPTH = 2
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire mifc_core_type core,
  output logic stack_full
);
  timeunit 1ns;
  timeprecision 1ns;
  int depth;
  // ==========================================================
  // stack depth, kept shallow so the full case is cheap to reach
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      depth <= 0;
    end else begin
      depth <= depth + int'(core.push) - int'(core.pop);
    end
  end
  assign stack_full = (depth >= DEPTH);
endmodule

//--- verification/mifc_top_tb.sv
// self-checking bench for the interrupt flag block with a core stack model
// assumes the apb answer and core strobes each stand for one cycle
module mifc_top_tb
  import mifc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  mifc_apb_req_type req = '0;
  mifc_apb_rsp_type rsp;
  mifc_core_type core;
  logic [NUM_SRC-1:0] ev = '0;
  logic full;
  logic rti = 1'b0;
  logic wake;
  logic [PC_W-1:0] pc = '0;
  logic [PC_W-1:0] pc_prev = '0;
  int n_errors = 0;
  int checked = 0;
  logic [32:0] q_rd[$];
  logic [PC_W-1:0] q_vec[$];
  logic [PC_W-1:0] vecs[NUM_SRC] = '{VEC_CMP_P, VEC_CMP_A, VEC_NVM, VEC_TICK0, VEC_TICK1};

  mifc_top uut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .src_event(ev), .stack_full(full), .next_pc(pc), .return_from_irq(rti),
    .core(core), .wake(wake));
  mifc_core_model #(.DEPTH(2)) model (.pclk(pclk), .presetn(presetn), .core(core),
    .stack_full(full));

  always #50 pclk = ~pclk;
  // random next-instruction address; the previous value is what a push saves
  always @(posedge pclk) begin
    pc_prev <= pc;
    pc <= 12'($urandom);
  end

  // ==========================================================
  // checking
  task automatic chk(input logic [32:0] got, input logic [32:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // negedge sampling, so one-cycle answers are settled and seen once
  always @(negedge pclk) begin
    if (rsp.pready === 1'b1 && !req.pwrite) begin
      if (q_rd.size() == 0) chk(1, 0, "unexpected read answer");
      else chk({rsp.pslverr, rsp.prdata}, q_rd.pop_front(), "read data");
    end
    if (core.push !== 1'b0) begin
      if (q_vec.size() == 0) begin
        chk(1, 0, "unexpected push");
      end else begin
        chk(33'(core.vector), 33'(q_vec.pop_front()), "vector");
        chk(33'(core.push_addr), 33'(pc_prev), "saved pc");
      end
    end
  end

  // ==========================================================
  // drivers
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
      input logic [32:0] e);
    if (!w) q_rd.push_back(e);
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'($urandom), d}};
    @(posedge pclk);
    req.penable <= 1'b1;
    // waits for pready with no timeout of its own; only the watchdog ends it if pready never comes
    do begin
      @(negedge pclk);
    end while (rsp.pready !== 1'b1);
    @(posedge pclk);
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic pulse_ev(input logic [NUM_SRC-1:0] m);
    @(posedge pclk);
    ev <= m;
    @(posedge pclk);
    ev <= '0;
  endtask

  task automatic ret();
    @(posedge pclk);
    rti <= 1'b1;
    @(posedge pclk);
    rti <= 1'b0;
  endtask

  task automatic report_and_stop();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // tests
  initial begin
    void'($urandom(61683));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    xfer(0, ADDR_FIRST, 0, 0);
    xfer(0, ADDR_SECOND, 0, 0);
    xfer(0, ADDR_THIRD, 0, 0);
    xfer(1, ADDR_THIRD, 8'hFF, 0);
    xfer(0, ADDR_THIRD, 0, 33'h11);
    pulse_ev(5'h1F);
    repeat (2) @(posedge pclk);
    chk(33'(wake), 33'h1, "wake with flags set");
    xfer(0, ADDR_SECOND, 0, 33'hF0);
    xfer(1, ADDR_SECOND, 8'hFF, 0);
    xfer(0, ADDR_SECOND, 0, 33'hFF);
    xfer(0, 8'h10, 0, 33'h100000000);
    // all five pending: one service per re-enable, in vector order
    for (int i = 0; i < NUM_SRC; i++) begin
      q_vec.push_back(vecs[i]);
      xfer(1, ADDR_FIRST, 8'h01, 0);
      xfer(0, ADDR_FIRST, 0, 0);
      ret();
    end
    xfer(0, ADDR_SECOND, 0, 33'h0F);
    xfer(0, ADDR_THIRD, 0, 33'h01);
    // fill the stack, then a third request must wait for a pop
    for (int i = 0; i < 3; i++) begin
      pulse_ev(5'h01);
      if (i < 2) q_vec.push_back(VEC_CMP_P);
      xfer(1, ADDR_FIRST, 8'h01, 0);
      repeat (3) @(posedge pclk);
    end
    xfer(0, ADDR_FIRST, 0, 33'h1);
    q_vec.push_back(VEC_CMP_P);
    ret();
    repeat (4) @(posedge pclk);
    chk(33'(q_vec.size() + q_rd.size()), 0, "expected results left over");
    chk(33'(wake), 0, "wake with no flags");
    report_and_stop();
  end

  initial begin
    repeat (5000) @(posedge pclk);
    n_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    report_and_stop();
  end
endmodule
